// File: hw/pwm_timing_pkg.sv
package pwm_timing_pkg;
   // register offsets
   localparam logic [7:0] off_ch1_dly = 8'h11;
   localparam logic [7:0] off_ch2_dly = 8'h12;
   localparam logic [7:0] off_inv1_dly = 8'h13;
   localparam logic [7:0] off_inv2_dly = 8'h14;
   localparam logic [7:0] off_held_mask = 8'h19;
   localparam logic [7:0] off_ramp = 8'h1a;
   localparam logic [7:0] off_osc_cal = 8'h1b;
   localparam logic [7:0] off_sys_ctrl2 = 8'h05;
   localparam logic [7:0] off_mod_mode = 8'h20;
   // reset values
   localparam logic [7:0] rst_dly_one = 8'hac;
   localparam logic [7:0] rst_dly_two = 8'h54;
   localparam logic [7:0] rst_held_mask = 8'h30;
   localparam logic [7:0] rst_ramp = 8'h0f;
   localparam logic [7:0] rst_osc_cal = 8'h82;
   localparam logic [7:0] rst_sys_ctrl2 = 8'h00;
   localparam logic [1:0] rst_mod_mode = 2'h0;
   // field positions
   localparam int dly_lsb = 2;
   localparam int dly_w = 6;
   localparam int dly_unit = 4;
   localparam int ramp_dis_bit = 7;
   localparam int ramp_code_w = 5;
   localparam int ramp_half_hi = 4;
   localparam int ramp_half_lo = 3;
   localparam int held_en_bit = 5;
   localparam int cal_done_bit = 6;
   localparam int cal_fact_bit = 1;
   localparam int mode_ch1_bit = 1;
   localparam int mode_ch2_bit = 0;
   localparam logic [7:0] cal_wr_mask = 8'h02;
   localparam logic [7:0] cal_fact_val = 8'h00;
   // timing: one 50% phase tick is 0.1 ms
   localparam int ramp_tick_us = 100;
   localparam int clk_mhz = 100;
   localparam int ramp_tick_cycles = ramp_tick_us * clk_mhz;
   localparam int cal_settle_cycles = 16;
   typedef enum logic [1:0] {st_off, st_ramp, st_run} ramp_state_t;
endpackage

// File: hw/edge_delay_line.sv
`timescale 1ns/100ps
module edge_delay_line
   import pwm_timing_pkg::*;
#(
   parameter int depth = 256
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // stream
   input wire logic pwm_in,
   input wire logic [7:0] tap,
   output logic pwm_out
);
   logic [depth-1:0] line_r;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         line_r <= '0;
      else
         line_r <= {line_r[depth-2:0], pwm_in};
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pwm_out <= 1'b0;
      else if (tap == 8'h00)
         pwm_out <= pwm_in;
      else
         pwm_out <= line_r[tap - 8'h01];
   end
endmodule

// File: hw/ramp_timer.sv
`timescale 1ns/100ps
module ramp_timer
   import pwm_timing_pkg::*;
#(
   parameter int tick_cycles = ramp_tick_cycles
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // control
   input wire logic start,
   input wire logic [17:0] ticks,
   output logic busy
);
   logic [31:0] pre_r;
   logic [17:0] left_r;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pre_r <= '0;
         left_r <= '0;
         busy <= 1'b0;
      end
      else if (start)
      begin
         pre_r <= '0;
         left_r <= ticks;
         busy <= (ticks != 18'h0);
      end
      else if (busy)
      begin
         if (pre_r == 32'(tick_cycles - 1))
         begin
            pre_r <= '0;
            left_r <= left_r - 18'h1;
            if (left_r == 18'h1)
               busy <= 1'b0;
         end
         else
            pre_r <= pre_r + 32'h1;
      end
   end
endmodule

// File: hw/pwm_channel_timing_control.sv
`timescale 1ns/100ps
module pwm_channel_timing_control
   import pwm_timing_pkg::*;
#(
   parameter int tick_cycles = ramp_tick_cycles
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // modulator side
   input wire logic [3:0] pwm_raw,
   input wire logic all_shutdown,
   input wire logic power_down_pin,
   // power stage side
   output logic [3:0] pwm_out,
   output logic [3:0] chan_run,
   output logic half_duty,
   output logic osc_trim_load,
   output logic osc_factory_sel
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] dly_r [4];
   logic [7:0] held_mask_r;
   logic [7:0] ramp_r;
   logic [7:0] sys_ctrl2_r;
   logic [1:0] mod_mode_r;
   logic cal_fact_r;
   logic cal_done_r;
   logic [4:0] cal_cnt_r;
   logic cal_busy_r;
   logic [2:0] pdn_sync_r;
   logic pdn_state_r;
   logic shut_prev_r;
   logic [7:0] tap [4];
   logic [3:0] pwm_dly;
   logic ramp_start;
   logic ramp_busy;
   logic [17:0] ramp_ticks;
   ramp_state_t state_r;

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         dly_r[0] <= rst_dly_one;
         dly_r[1] <= rst_dly_two;
         dly_r[2] <= rst_dly_one;
         dly_r[3] <= rst_dly_two;
         held_mask_r <= rst_held_mask;
         ramp_r <= rst_ramp;
         sys_ctrl2_r <= rst_sys_ctrl2;
         mod_mode_r <= rst_mod_mode;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            off_ch1_dly: dly_r[0] <= reg_wdata;
            off_ch2_dly: dly_r[1] <= reg_wdata;
            off_inv1_dly: dly_r[2] <= reg_wdata;
            off_inv2_dly: dly_r[3] <= reg_wdata;
            off_held_mask: held_mask_r <= reg_wdata;
            off_ramp: ramp_r <= reg_wdata;
            off_sys_ctrl2: sys_ctrl2_r <= reg_wdata;
            off_mod_mode: mod_mode_r <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator calibration
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cal_fact_r <= 1'b1;
         cal_done_r <= 1'b0;
         cal_busy_r <= 1'b0;
         cal_cnt_r <= '0;
      end
      else if (reg_wr && reg_addr == off_osc_cal)
      begin
         // a zero byte always means factory trim
         cal_fact_r <= (reg_wdata == cal_fact_val) ? 1'b0 :
            reg_wdata[cal_fact_bit];
         cal_done_r <= 1'b0;
         cal_busy_r <= 1'b1;
         cal_cnt_r <= '0;
      end
      else if (cal_busy_r)
      begin
         cal_cnt_r <= cal_cnt_r + 5'h1;
         if (cal_cnt_r == 5'(cal_settle_cycles - 1))
         begin
            cal_busy_r <= 1'b0;
            cal_done_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         osc_trim_load <= 1'b0;
         osc_factory_sel <= 1'b0;
      end
      else
      begin
         // trim stays applied while settling so rate detect sees it
         osc_trim_load <= cal_busy_r;
         osc_factory_sel <= ~cal_fact_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            off_ch1_dly: reg_rdata <= {dly_r[0][7:2], 2'h0};
            off_ch2_dly: reg_rdata <= {dly_r[1][7:2], 2'h0};
            off_inv1_dly: reg_rdata <= {dly_r[2][7:2], 2'h0};
            off_inv2_dly: reg_rdata <= {dly_r[3][7:2], 2'h0};
            off_held_mask: reg_rdata <= held_mask_r;
            off_ramp: reg_rdata <= ramp_r;
            off_sys_ctrl2: reg_rdata <= sys_ctrl2_r;
            off_mod_mode: reg_rdata <= {6'h0, mod_mode_r};
            off_osc_cal: reg_rdata <= {1'b1, cal_done_r, 4'h0,
               cal_fact_r, 1'b0};
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // power-down pin synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         pdn_sync_r <= '0;
         pdn_state_r <= 1'b0;
         shut_prev_r <= 1'b1;
      end
      else
      begin
         pdn_sync_r <= {pdn_sync_r[1:0], power_down_pin};
         if (pdn_sync_r[2] == pdn_sync_r[1])
            pdn_state_r <= pdn_sync_r[2];
         shut_prev_r <= all_shutdown;
      end
   end

   logic pdn_prev_r;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pdn_prev_r <= 1'b0;
      else
         pdn_prev_r <= pdn_state_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // soft ramp
   logic ramp_event;
   logic ramp_on;
   assign ramp_event = (shut_prev_r != all_shutdown) ||
      (pdn_prev_r != pdn_state_r);
   assign ramp_on = ramp_r[ramp_half_hi] | ramp_r[ramp_half_lo];
   assign ramp_start = ramp_event && !ramp_r[ramp_dis_bit] && ramp_on;

   // tenths of ms; table figures carried as constants
   always_comb
   begin
      unique case (ramp_r[ramp_code_w-1:0])
         5'h08: ramp_ticks = 18'd165;
         5'h09: ramp_ticks = 18'd239;
         5'h0a: ramp_ticks = 18'd314;
         5'h0b: ramp_ticks = 18'd404;
         5'h0c: ramp_ticks = 18'd539;
         5'h0d: ramp_ticks = 18'd703;
         5'h0e: ramp_ticks = 18'd942;
         5'h0f: ramp_ticks = 18'd1257;
         5'h10: ramp_ticks = 18'd1646;
         5'h11: ramp_ticks = 18'd2394;
         5'h12: ramp_ticks = 18'd3142;
         5'h13: ramp_ticks = 18'd4039;
         5'h14: ramp_ticks = 18'd5386;
         5'h15: ramp_ticks = 18'd7031;
         5'h16: ramp_ticks = 18'd9425;
         5'h17: ramp_ticks = 18'd12566;
         5'h18: ramp_ticks = 18'd17281;
         5'h19: ramp_ticks = 18'd25136;
         5'h1a: ramp_ticks = 18'd32991;
         5'h1b: ramp_ticks = 18'd42417;
         5'h1c: ramp_ticks = 18'd56556;
         5'h1d: ramp_ticks = 18'd73837;
         5'h1e: ramp_ticks = 18'd98973;
         5'h1f: ramp_ticks = 18'd131964;
         default: ramp_ticks = 18'd0;
      endcase
   end

   ramp_timer #(.tick_cycles(tick_cycles)) u_ramp (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(ramp_start),
      .ticks(ramp_ticks),
      .busy(ramp_busy)
   );

   logic stopped;
   assign stopped = all_shutdown | pdn_state_r;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         state_r <= st_off;
      else
      begin
         unique case (state_r)
            st_off: if (ramp_start) state_r <= st_ramp;
               else if (!stopped) state_r <= st_run;
            st_ramp: if (!ramp_busy && !ramp_start)
               state_r <= stopped ? st_off : st_run;
            st_run: if (ramp_start) state_r <= st_ramp;
               else if (stopped) state_r <= st_off;
            // the fourth code of the two-bit state is unused; park it
            default: state_r <= st_off;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel delay; taps are offset by 32 units so negatives stay causal
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ch
         logic signed [dly_w-1:0] field;
         assign field = dly_r[g][dly_lsb +: dly_w];
         // bias +32 units: -32 maps to zero shift on the common reference
         assign tap[g] = 8'((7'(field) + 7'h20) * dly_unit);
         edge_delay_line u_dly (
            .ref_clk(ref_clk),
            .reset(reset),
            .pwm_in(pwm_raw[g]),
            .tap(tap[g]),
            .pwm_out(pwm_dly[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // output gating
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         chan_run <= '0;
         pwm_out <= '0;
         half_duty <= 1'b0;
      end
      else
      begin
         half_duty <= (state_r == st_ramp);
         if (state_r == st_run)
            // held group stays idle unless the control bit lets it go
            chan_run <= sys_ctrl2_r[held_en_bit] ? 4'hf :
               ~held_mask_r[3:0];
         else
            chan_run <= 4'h0;
         pwm_out <= pwm_dly & chan_run;
      end
   end
endmodule

// File: verif/pwm_timing_sva.sv
`timescale 1ns/100ps
module pwm_timing_sva
   import pwm_timing_pkg::*;
#(
   parameter int tick_cycles = ramp_tick_cycles
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // modulator side
   input wire logic [3:0] pwm_raw,
   input wire logic all_shutdown,
   input wire logic power_down_pin,
   // power stage side
   input wire logic [3:0] pwm_out,
   input wire logic [3:0] chan_run,
   input wire logic half_duty,
   input wire logic osc_trim_load,
   input wire logic osc_factory_sel
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   a_unmapped_zero: assert property (
      $past(reg_rd) && $past(reg_addr) == 8'h15 |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_dly_low_bits: assert property (
      $past(reg_rd) && $past(reg_addr) inside {[off_ch1_dly:off_inv2_dly]}
      |-> reg_rdata[1:0] == 2'h0)
      else $error("delay read low bits set");
   a_cal_fixed_bits: assert property (
      $past(reg_rd) && $past(reg_addr) == off_osc_cal
      |-> reg_rdata[7] && reg_rdata[5:2] == 4'h0 && !reg_rdata[0])
      else $error("calibration fixed bits wrong");
   a_trim_clears: assert property (
      reg_wr && reg_addr == off_osc_cal ##1 reg_rd && reg_addr == off_osc_cal
      |=> !reg_rdata[cal_done_bit])
      else $error("done seen right after trim request");
   a_trim_starts: assert property (
      reg_wr && reg_addr == off_osc_cal |-> ##[1:2] osc_trim_load)
      else $error("trim load not started");
   // settling must not be cut short, nor hang
   a_trim_settle: assert property (
      $rose(osc_trim_load) |-> osc_trim_load [*8] ##[1:12] !osc_trim_load)
      else $error("trim settle length wrong");
   a_factory_on: assert property (
      reg_wr && reg_addr == off_osc_cal && !reg_wdata[cal_fact_bit]
      |-> ##[1:2] osc_factory_sel)
      else $error("factory trim not selected");
   a_factory_off: assert property (
      reg_wr && reg_addr == off_osc_cal && reg_wdata[cal_fact_bit]
      |-> ##[1:2] !osc_factory_sel)
      else $error("factory trim not released");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pwm_channel_timing_control pwm_timing_sva #(.tick_cycles(tick_cycles))
   u_sva (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pwm_raw(pwm_raw), .all_shutdown(all_shutdown),
   .power_down_pin(power_down_pin), .pwm_out(pwm_out), .chan_run(chan_run),
   .half_duty(half_duty), .osc_trim_load(osc_trim_load),
   .osc_factory_sel(osc_factory_sel));

// File: verif/power_stage_model.sv
`timescale 1ns/100ps
module power_stage_model
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // bridge drive
   input wire logic [3:0] pwm_out,
   output logic [63:0] rise_cnt
);
   logic [3:0] last_r;
   ////////////////////////////////////////////////////////////////////////////
   // one 16-bit rising-edge counter per half bridge; wraps silently
   always_ff @(posedge ref_clk)
   begin
      last_r <= pwm_out;
      for (int i = 0; i < 4; i++)
         if (pwm_out[i] && !last_r[i])
            rise_cnt[16*i +: 16] <= rise_cnt[16*i +: 16] + 16'h0001;
      if (reset)
         rise_cnt <= '0;
   end
endmodule

// File: verif/tb_pwm_channel_timing_control.sv
`timescale 1ns/100ps
module tb_pwm_channel_timing_control;
   import pwm_timing_pkg::*;
   localparam int tick_c = 10;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic raw = 1'b0;
   logic all_shutdown = 1'b1;
   logic power_down_pin = 1'b0;
   logic [3:0] pwm_out;
   logic [3:0] chan_run;
   logic half_duty;
   logic osc_trim_load;
   logic osc_factory_sel;
   logic [63:0] rise_cnt;
   logic [63:0] e;
   logic [7:0] rv;
   int err_total = 0;
   int checks_done = 0;
   int n0, n1, n2, n;
   logic [7:0] ra [9] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h1a, 8'h1b,
      8'h05, 8'h20};
   logic [7:0] re [9] = '{8'hac, 8'h54, 8'hac, 8'h54, 8'h30, 8'h0f, 8'h82,
      8'h00, 8'h00};
   logic [7:0] bd [4] = '{8'hb8, 8'h60, 8'ha0, 8'h48};
   logic [7:0] rc [5] = '{8'h08, 8'h09, 8'h00, 8'h88, 8'h0f};
   bit rp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   int rx [5] = '{165, 239, 0, 0, 1257};
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////
   pwm_channel_timing_control #(.tick_cycles(tick_c)) DUT (.ref_clk(ref_clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pwm_raw({4{raw}}), .all_shutdown(all_shutdown),
      .power_down_pin(power_down_pin), .pwm_out(pwm_out),
      .chan_run(chan_run), .half_duty(half_duty),
      .osc_trim_load(osc_trim_load), .osc_factory_sel(osc_factory_sel));
   power_stage_model stage (.ref_clk(ref_clk), .reset(reset),
      .pwm_out(pwm_out), .rise_cnt(rise_cnt));
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // write then read with no idle cycle between the two strobes
   task automatic wrrd(input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp, input int tol);
      checks_done++;
      if (got > exp + tol || got < exp - tol)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk8(d, exp);
   endtask
   // waits stay bounded so a dead output shows as a count, not a hang
   task automatic meas(input logic [7:0] f, output int c);
      wr(off_ch1_dly, f);
      c = 0;
      @(posedge ref_clk);
      raw <= 1'b1;
      while (pwm_out[0] !== 1'b1 && c < 400)
      begin
         @(posedge ref_clk);
         #1;
         c++;
      end
      @(posedge ref_clk);
      raw <= 1'b0;
      repeat (300) @(posedge ref_clk);
   endtask
   task automatic cycle_sd();
      @(posedge ref_clk);
      all_shutdown <= 1'b1;
      repeat (20) @(posedge ref_clk);
      all_shutdown <= 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
   endtask
   task automatic pulse();
      @(posedge ref_clk);
      raw <= 1'b1;
      repeat (300) @(posedge ref_clk);
      raw <= 1'b0;
      repeat (300) @(posedge ref_clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      err_total++;
      test_done();
   end
   initial
   begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++)
         rchk(ra[i], re[i]);
      rchk(8'h15, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 4; i++)
         wr(off_ch1_dly + 8'(i), bd[i]);
      for (int i = 0; i < 4; i++)
         rchk(off_ch1_dly + 8'(i), bd[i]);
      wr(off_inv1_dly, 8'hff);
      rchk(off_inv1_dly, 8'hfc);
      wr(off_inv1_dly, 8'ha0);
      wr(off_held_mask, 8'h3a);
      rchk(off_held_mask, 8'h3a);
      wr(off_held_mask, 8'h30);
      wr(off_mod_mode, 8'hff);
      rchk(off_mod_mode, 8'h03);
      $display("register access done");
      // trim is started before anything leans on rate detection
      wrrd(off_osc_cal, cal_fact_val, rv);
      chk8(rv, 8'h80);
      repeat (20) @(posedge ref_clk);
      rchk(off_osc_cal, 8'hc0);
      chk8({7'h0, osc_factory_sel}, 8'h01);
      wrrd(off_osc_cal, 8'h42, rv);
      chk8(rv, 8'h82);
      repeat (20) @(posedge ref_clk);
      rchk(off_osc_cal, 8'hc2);
      chk8({7'h0, osc_factory_sel}, 8'h00);
      $display("trim done");
      for (int i = 0; i < 5; i++)
      begin
         wr(off_ramp, rc[i]);
         @(posedge ref_clk);
         if (rp[i])
            power_down_pin <= ~power_down_pin;
         else
            all_shutdown <= ~all_shutdown;
         n = 0;
         n0 = 0;
         while (half_duty !== 1'b1 && n0 < 40)
         begin
            @(posedge ref_clk);
            #1;
            n0++;
         end
         while (half_duty === 1'b1 && n < 30000)
         begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         chkn(n, rx[i] * tick_c, tick_c + 4);
      end
      $display("soft ramp done");
      wr(off_ramp, 8'h80);
      meas(8'h80, n0);
      meas(8'h00, n1);
      meas(8'h7c, n2);
      chkn(n1 - n0, 128, 0);
      chkn(n2 - n0, 252, 0);
      $display("edge delay done");
      wr(off_held_mask, 8'h32);
      cycle_sd();
      chk8({4'h0, chan_run}, 8'h0d);
      e = rise_cnt;
      pulse();
      chk8(rise_cnt[7:0] - e[7:0], 8'h01);
      chk8(rise_cnt[23:16] - e[23:16], 8'h00);
      chk8(rise_cnt[39:32] - e[39:32], 8'h01);
      chk8(rise_cnt[55:48] - e[55:48], 8'h01);
      wr(off_sys_ctrl2, 8'h20);
      cycle_sd();
      chk8({4'h0, chan_run}, 8'h0f);
      $display("held group done");
      test_done();
   end
endmodule
